// ===== logic/amou_regs.svh
`ifndef AMOU_REGS_SVH
`define AMOU_REGS_SVH
`define AMOU_WORD_W 24
`define AMOU_ADDR_W 14
`define AMOU_OPC_W 7
`define AMOU_BIT_RELOC 23
`define AMOU_BIT_INDEX 22
`define AMOU_BIT_TRAP 21
`define AMOU_OPC_HI 21
`define AMOU_OPC_LO 15
`define AMOU_BIT_INDIR 14
`define AMOU_BIT_SIGN 23
`define AMOU_OP_SKIP_SIG 7'h20
`define AMOU_OP_OUT_PULSE 7'h02
`define AMOU_OP_MARK_BR 7'h23
`define AMOU_OP_RET_BR 7'h29
`define AMOU_SAVE_ADDR 14'h0000
`define AMOU_TRAP_BASE 14'h0040
`define AMOU_MODULE_WORDS 4096
`define AMOU_PC_RESET 14'h0000
`endif

// ===== logic/amou_pkg.sv
package amou_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_FWAIT, ST_MODIFY, ST_IWAIT, ST_EXEC,
    ST_WWAIT, ST_TSAVE, ST_TWAIT, ST_HALT
  } amou_state_t;
endpackage

// ===== logic/amou_core.sv
// Functional notes
// - Index flag set: add index register low bits to the address field.
// - Program counter holds current address; steps by one unless altered.
// - Memory address register presents every fetch and data access.
// - Opcode register holds the code of the executing instruction.
// - Instruction held unmodified in fetch register; modification and parity use the read word.
// - Read word captured in memory data register; restore comes from it.
// - One to four modules of 4096 words; 24 data bits plus parity.
// - Check supply before each access; halt instead when inadequate.
// - Stored words carry even parity over all 25 bits.
// - Parity checked on every read; halt on error if switch set.
// - Add or subtract overflow sets the overflow indicator.
// - Most negative word squared sets the overflow indicator.
// - Divide with numerator magnitude not below denominator sets it.
// - Left shift of a one past position 1 sets it.
// - Skip-on-signal tests then clears; output pulse just clears.
// - Overflow indicator is sticky until explicitly cleared.
// - Trap opcode saves indicator into bit 0 of location 00, clears it.
// - Mark-place-and-branch writes indicator to bit 0, keeps it.
// - Return branch ORs bit 0 of the operand word into indicator.
// - Indirect flag chains address words without limit.
// - Indexing applied at each level before the indirect flag test.
// - Codes 00-77 decode normally; 100-177 enter trap subroutines.
// - Modification affects only the internal copy, never memory.
// - Bit 2 is the trap flag; else bits 3-8 are the opcode.
// - Relocation bit 0 is ignored by execution.
// - Indexing costs no time; each indirect level costs one more memory read (at least two clock cycles).
`timescale 1ns/1ps
`default_nettype none
`include "amou_regs.svh"
module amou_core #(
  parameter int MODULES = 4
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic RUN,
  input wire logic POWER_OK,
  input wire logic HALT_ON_PARITY,
  input wire logic [`AMOU_WORD_W-1:0] INDEX_REG,
  input wire logic MEM_ACK,
  input wire logic [`AMOU_WORD_W-1:0] MEM_RDATA,
  input wire logic MEM_RPAR,
  input wire logic EXEC_DONE,
  input wire logic EXEC_PC_LOAD,
  input wire logic [`AMOU_ADDR_W-1:0] EXEC_PC_VALUE,
  input wire logic EXEC_WRITE,
  input wire logic [`AMOU_WORD_W-1:0] EXEC_WDATA,
  input wire logic ADD_OVF,
  input wire logic MUL_MAX_NEG,
  input wire logic DIV_OVF,
  input wire logic SHIFT_OVF,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [`AMOU_ADDR_W-1:0] MEM_ADDR,
  output logic [`AMOU_WORD_W-1:0] MEM_WDATA,
  output logic MEM_WPAR,
  output logic [`AMOU_ADDR_W-1:0] PC,
  output logic [`AMOU_OPC_W-1:0] OPCODE,
  output logic [`AMOU_WORD_W-1:0] INSTR,
  output logic [`AMOU_WORD_W-1:0] MEM_DATA,
  output logic [`AMOU_ADDR_W-1:0] EFF_ADDR,
  output logic EXEC_START,
  output logic SKIP_TAKEN,
  output logic OVERFLOW,
  output logic PARITY_ERR,
  output logic POWER_HALT,
  output logic HALTED
);
  initial
  begin
    if (MODULES < 1 || MODULES > 4)
      $error("MODULES must be 1 to 4");
  end

  localparam int MEM_WORDS = MODULES * `AMOU_MODULE_WORDS;

  amou_pkg::amou_state_t state_q;
  logic [`AMOU_ADDR_W-1:0] pc_q;
  logic [`AMOU_ADDR_W-1:0] mar_q;
  logic [`AMOU_OPC_W-1:0] opc_q;
  logic [`AMOU_WORD_W-1:0] c_q;
  logic [`AMOU_WORD_W-1:0] m_q;
  logic [`AMOU_ADDR_W-1:0] ea_q;
  logic req_q;
  logic we_q;
  logic [`AMOU_WORD_W-1:0] wdata_q;
  logic wpar_q;
  logic start_q;
  logic skip_q;
  logic ovf_q;
  logic perr_q;
  logic phalt_q;
  logic fetch_op_q;
  logic opr_q;
  logic [`AMOU_OPC_W-1:0] cur_opc;
  logic [`AMOU_ADDR_W-1:0] idx_addr;
  logic [`AMOU_ADDR_W-1:0] rd_mod;
  logic rd_perr;
  logic [`AMOU_WORD_W-1:0] wr_word;

  function automatic logic even_par(input logic [`AMOU_WORD_W-1:0] w);
    even_par = ^w;
  endfunction

  // Index and address field share one adder for every level
  function automatic logic [`AMOU_ADDR_W-1:0] modify(
    input logic [`AMOU_WORD_W-1:0] w,
    input logic [`AMOU_ADDR_W-1:0] x);
    if (w[`AMOU_BIT_INDEX])
      modify = w[`AMOU_ADDR_W-1:0] + x;
    else
      modify = w[`AMOU_ADDR_W-1:0];
  endfunction

  function automatic logic in_range(input logic [`AMOU_ADDR_W-1:0] a);
    in_range = (32'(a) < MEM_WORDS);
  endfunction

  assign idx_addr = INDEX_REG[`AMOU_ADDR_W-1:0];
  assign rd_mod = modify(MEM_RDATA, idx_addr);
  assign rd_perr = (even_par(MEM_RDATA) != MEM_RPAR);
  // Sign bit is the leftmost bit 0 in machine numbering
  assign wr_word = EXEC_WDATA;
  assign cur_opc = fetch_op_q ? MEM_RDATA[`AMOU_OPC_HI:`AMOU_OPC_LO] : opc_q;

  // Sequencer; a failing supply check halts before any access begins
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      state_q <= amou_pkg::ST_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      start_q <= 1'b0;
      phalt_q <= 1'b0;
      perr_q <= 1'b0;
      fetch_op_q <= 1'b0;
      opr_q <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      case (state_q)
        amou_pkg::ST_IDLE:
        begin
          if (RUN)
            state_q <= amou_pkg::ST_FETCH;
        end
        amou_pkg::ST_FETCH:
        begin
          if (!POWER_OK)
          begin
            phalt_q <= 1'b1;
            state_q <= amou_pkg::ST_HALT;
          end
          else
          begin
            req_q <= 1'b1;
            we_q <= 1'b0;
            fetch_op_q <= 1'b1;
            state_q <= amou_pkg::ST_FWAIT;
          end
        end
        amou_pkg::ST_FWAIT, amou_pkg::ST_IWAIT:
        begin
          if (MEM_ACK)
          begin
            req_q <= 1'b0;
            perr_q <= rd_perr;
            opr_q <= 1'b0;
            if (rd_perr && HALT_ON_PARITY)
              state_q <= amou_pkg::ST_HALT;
            else if (opr_q)
            begin
              // Operand word of a return branch is never an address word
              start_q <= 1'b1;
              state_q <= amou_pkg::ST_EXEC;
            end
            else if (fetch_op_q && MEM_RDATA[`AMOU_BIT_TRAP])
              state_q <= amou_pkg::ST_TSAVE;
            else if (MEM_RDATA[`AMOU_BIT_INDIR])
            begin
              if (!POWER_OK)
              begin
                phalt_q <= 1'b1;
                state_q <= amou_pkg::ST_HALT;
              end
              else
              begin
                req_q <= 1'b1;
                state_q <= amou_pkg::ST_IWAIT;
              end
            end
            else if (cur_opc == `AMOU_OP_RET_BR)
            begin
              if (!POWER_OK)
              begin
                phalt_q <= 1'b1;
                state_q <= amou_pkg::ST_HALT;
              end
              else
              begin
                req_q <= 1'b1;
                opr_q <= 1'b1;
                state_q <= amou_pkg::ST_IWAIT;
              end
            end
            else
            begin
              start_q <= 1'b1;
              state_q <= amou_pkg::ST_EXEC;
            end
            fetch_op_q <= 1'b0;
          end
        end
        amou_pkg::ST_EXEC:
        begin
          if (EXEC_WRITE)
          begin
            if (!POWER_OK)
            begin
              phalt_q <= 1'b1;
              state_q <= amou_pkg::ST_HALT;
            end
            else
            begin
              req_q <= 1'b1;
              we_q <= 1'b1;
              state_q <= amou_pkg::ST_WWAIT;
            end
          end
          else if (EXEC_DONE)
            state_q <= RUN ? amou_pkg::ST_FETCH : amou_pkg::ST_IDLE;
        end
        amou_pkg::ST_WWAIT:
        begin
          if (MEM_ACK)
          begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            state_q <= amou_pkg::ST_EXEC;
          end
        end
        amou_pkg::ST_TSAVE:
        begin
          if (!POWER_OK)
          begin
            phalt_q <= 1'b1;
            state_q <= amou_pkg::ST_HALT;
          end
          else
          begin
            req_q <= 1'b1;
            we_q <= 1'b1;
            state_q <= amou_pkg::ST_TWAIT;
          end
        end
        amou_pkg::ST_TWAIT:
        begin
          if (MEM_ACK)
          begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            state_q <= RUN ? amou_pkg::ST_FETCH : amou_pkg::ST_IDLE;
          end
        end
        amou_pkg::ST_HALT:
        begin
          if (!RUN)
          begin
            phalt_q <= 1'b0;
            state_q <= amou_pkg::ST_IDLE;
          end
        end
        default:
          state_q <= amou_pkg::ST_IDLE;
      endcase
    end
  end

  // Memory address register drives every access
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      mar_q <= `AMOU_PC_RESET;
    else if (state_q == amou_pkg::ST_IDLE)
      mar_q <= pc_q;
    else if (state_q == amou_pkg::ST_FETCH)
      mar_q <= pc_q;
    else if (state_q == amou_pkg::ST_TSAVE)
      mar_q <= `AMOU_SAVE_ADDR;
    else if ((state_q == amou_pkg::ST_FWAIT ||
              state_q == amou_pkg::ST_IWAIT) && MEM_ACK)
      mar_q <= rd_mod;
    else if (state_q == amou_pkg::ST_EXEC && EXEC_WRITE)
      mar_q <= ea_q;
  end

  // Fetch register keeps the unmodified copy; memory never sees the sum
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      c_q <= '0;
      opc_q <= '0;
      ea_q <= '0;
      m_q <= '0;
    end
    else if ((state_q == amou_pkg::ST_FWAIT ||
              state_q == amou_pkg::ST_IWAIT) && MEM_ACK)
    begin
      m_q <= MEM_RDATA;
      if (!opr_q)
        ea_q <= rd_mod;
      if (fetch_op_q)
      begin
        c_q <= MEM_RDATA;
        opc_q <= MEM_RDATA[`AMOU_OPC_HI:`AMOU_OPC_LO];
      end
    end
  end

  // Write data: trap save records the trap instruction's own address, overflow in sign bit
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      wdata_q <= '0;
      wpar_q <= 1'b0;
    end
    else if (state_q == amou_pkg::ST_TSAVE)
    begin
      wdata_q <= {ovf_q, 9'h000, pc_q};
      wpar_q <= even_par({ovf_q, 9'h000, pc_q});
    end
    else if (state_q == amou_pkg::ST_EXEC && EXEC_WRITE)
    begin
      if (opc_q == `AMOU_OP_MARK_BR)
      begin
        wdata_q <= {ovf_q, wr_word[`AMOU_WORD_W-2:0]};
        wpar_q <= even_par({ovf_q, wr_word[`AMOU_WORD_W-2:0]});
      end
      else
      begin
        wdata_q <= wr_word;
        wpar_q <= even_par(wr_word);
      end
    end
    else if (state_q == amou_pkg::ST_FWAIT || state_q == amou_pkg::ST_IWAIT)
    begin
      wdata_q <= m_q;
      wpar_q <= even_par(m_q);
    end
  end

  // Program counter; a trap enters at a per-code entry
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      pc_q <= `AMOU_PC_RESET;
    else if (state_q == amou_pkg::ST_TWAIT && MEM_ACK)
      pc_q <= `AMOU_TRAP_BASE | {8'h00, c_q[`AMOU_OPC_LO+5:`AMOU_OPC_LO]};
    else if (state_q == amou_pkg::ST_EXEC && EXEC_DONE && !EXEC_WRITE)
    begin
      if (EXEC_PC_LOAD)
        pc_q <= EXEC_PC_VALUE;
      else
        pc_q <= pc_q + 14'h0001;
    end
  end

  // Overflow: sets win over clears so no event is lost
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      ovf_q <= 1'b0;
      skip_q <= 1'b0;
    end
    else
    begin
      if (start_q && opc_q == `AMOU_OP_SKIP_SIG)
        skip_q <= !ovf_q;
      if (ADD_OVF || MUL_MAX_NEG || DIV_OVF || SHIFT_OVF)
        ovf_q <= 1'b1;
      else if (start_q && opc_q == `AMOU_OP_RET_BR)
        ovf_q <= ovf_q | m_q[`AMOU_BIT_SIGN];
      else if (start_q && (opc_q == `AMOU_OP_SKIP_SIG ||
                           opc_q == `AMOU_OP_OUT_PULSE))
        ovf_q <= 1'b0;
      else if (state_q == amou_pkg::ST_TWAIT && MEM_ACK)
        ovf_q <= 1'b0;
    end
  end

  assign MEM_REQ = req_q;
  assign MEM_WE = we_q;
  assign MEM_ADDR = mar_q;
  assign MEM_WDATA = wdata_q;
  assign MEM_WPAR = wpar_q;
  assign PC = pc_q;
  assign OPCODE = opc_q;
  assign INSTR = c_q;
  assign MEM_DATA = m_q;
  assign EFF_ADDR = ea_q;
  assign EXEC_START = start_q;
  assign SKIP_TAKEN = skip_q;
  assign OVERFLOW = ovf_q;
  assign PARITY_ERR = perr_q;
  assign POWER_HALT = phalt_q;
  assign HALTED = (state_q == amou_pkg::ST_HALT);
endmodule
`default_nettype wire

// ===== testbench/amou_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module amou_core_chk #(
  parameter int MODULES = 4
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic HALT_ON_PARITY,
  input wire logic MEM_ACK,
  input wire logic [23:0] MEM_RDATA,
  input wire logic MEM_RPAR,
  input wire logic EXEC_DONE,
  input wire logic EXEC_PC_LOAD,
  input wire logic ADD_OVF,
  input wire logic MUL_MAX_NEG,
  input wire logic DIV_OVF,
  input wire logic SHIFT_OVF,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [13:0] MEM_ADDR,
  input wire logic [23:0] MEM_WDATA,
  input wire logic MEM_WPAR,
  input wire logic [13:0] PC,
  input wire logic [23:0] MEM_DATA,
  input wire logic EXEC_START,
  input wire logic OVERFLOW,
  input wire logic PARITY_ERR,
  input wire logic POWER_HALT,
  input wire logic HALTED
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);
  AST_REQ_HOLD: assert property (
    MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("memory request dropped or moved before ack");
  AST_WPAR: assert property (
    MEM_REQ && MEM_WE |-> MEM_WPAR == ^MEM_WDATA)
    else $error("stored word parity is not even");
  AST_PWR: assert property (
    POWER_HALT |-> HALTED && !MEM_REQ)
    else $error("access while supply halt");
  AST_OVF_SET: assert property (
    ADD_OVF || MUL_MAX_NEG || DIV_OVF || SHIFT_OVF |=> OVERFLOW)
    else $error("overflow event not recorded");
  AST_STICKY: assert property (
    OVERFLOW && !EXEC_START && !EXEC_DONE && !MEM_ACK |=> OVERFLOW)
    else $error("overflow dropped without a clearing step");
  AST_START: assert property (
    EXEC_START |-> $past(MEM_ACK) ##1 !EXEC_START)
    else $error("execution start not one cycle after last read");
  AST_MDR: assert property (
    MEM_REQ && MEM_ACK && !MEM_WE |=> MEM_DATA == $past(MEM_RDATA))
    else $error("read word not captured");
  AST_PAR: assert property (
    MEM_REQ && MEM_ACK && !MEM_WE && HALT_ON_PARITY &&
    (^{MEM_RDATA, MEM_RPAR}) |=> PARITY_ERR ##[0:2] HALTED)
    else $error("parity error did not halt");
  AST_PC_STEP: assert property (
    EXEC_DONE && !EXEC_PC_LOAD |=> PC == $past(PC) + 14'h0001)
    else $error("program counter did not step by one");
  // Reach checks only, not pass criteria
  cover property (MEM_REQ && MEM_WE && MEM_ACK);
  cover property (PARITY_ERR && HALTED);
  cover property (POWER_HALT);
endmodule
bind amou_core amou_core_chk #(.MODULES(MODULES)) u_chk (.*);
`default_nettype wire

// ===== testbench/amou_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module amou_mem_model (
  input wire logic clk,
  input wire logic [3:0] lat,
  input wire logic req,
  input wire logic we,
  input wire logic [13:0] addr,
  input wire logic [23:0] wdata,
  input wire logic wpar,
  output logic ack,
  output logic [23:0] rdata,
  output logic rpar
);
  logic [24:0] mem [0:16383];
  logic [3:0] cnt;
  initial
  begin
    ack = 1'b0;
    cnt = 4'h0;
    rdata = 24'h000000;
    rpar = 1'b0;
  end
  // Data toggles when not answering a read so a stale word never looks valid
  always @(posedge clk)
  begin
    ack <= 1'b0;
    rdata <= ~rdata;
    rpar <= ~rpar;
    if (req && !ack)
    begin
      if (cnt >= lat)
      begin
        cnt <= 4'h0;
        ack <= 1'b1;
        if (we)
          mem[addr] <= {wdata, wpar};
        else
          {rdata, rpar} <= mem[addr];
      end
      else
        cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb_address_modify_overflow_unit.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_address_modify_overflow_unit;
  logic CORE_CLK, RST_B, RUN, POWER_OK, HALT_ON_PARITY, MEM_ACK, MEM_RPAR;
  logic EXEC_DONE, EXEC_PC_LOAD, EXEC_WRITE, ADD_OVF, MUL_MAX_NEG, DIV_OVF;
  logic SHIFT_OVF, MEM_REQ, MEM_WE, MEM_WPAR, EXEC_START, SKIP_TAKEN;
  logic OVERFLOW, PARITY_ERR, POWER_HALT, HALTED;
  logic [23:0] INDEX_REG, MEM_RDATA, EXEC_WDATA, MEM_WDATA, INSTR, MEM_DATA;
  logic [13:0] EXEC_PC_VALUE, MEM_ADDR, PC, EFF_ADDR;
  logic [6:0] OPCODE;
  logic [3:0] lat;
  int n_errors, compares, acks, k;
  amou_core dut (.*);
  amou_mem_model u_mem (.clk(CORE_CLK), .lat(lat), .req(MEM_REQ),
    .we(MEM_WE), .addr(MEM_ADDR), .wdata(MEM_WDATA), .wpar(MEM_WPAR),
    .ack(MEM_ACK), .rdata(MEM_RDATA), .rpar(MEM_RPAR));
  initial
  begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK)
    if (MEM_ACK === 1'b1) acks++;
  function automatic logic [23:0] mk(input logic x, input logic [6:0] op,
    input logic ind, input logic [13:0] a);
    return {1'b0, x, op, ind, a};
  endfunction
  task automatic poke(input logic [13:0] a, input logic [23:0] w);
    u_mem.mem[a] = {w, ^w};
  endtask
  task automatic tick;
    @(posedge CORE_CLK) #1;
  endtask
  task automatic summarize;
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One instruction: checks at start, events and write, then completion
  task automatic do_ex(input logic [13:0] pc, eff, input logic [6:0] opc,
    input int na, input logic [3:0] ev, input logic wr, ld, sk, ovf);
    for (k = 0; k < 80 && EXEC_START !== 1'b1; k++) tick();
    `CHK("pc", pc, PC)
    `CHK("eff", eff, EFF_ADDR)
    `CHK("opcode", opc, OPCODE)
    `CHK("reads", na, acks)
    tick();
    {ADD_OVF, MUL_MAX_NEG, DIV_OVF, SHIFT_OVF} = ev;
    EXEC_WRITE = wr;
    tick();
    {ADD_OVF, MUL_MAX_NEG, DIV_OVF, SHIFT_OVF} = 4'h0;
    EXEC_WRITE = 1'b0;
    if (wr)
      for (k = 0; k < 40 && MEM_ACK !== 1'b1; k++) tick();
    tick();
    if (opc === 7'h20) `CHK("skip", sk, SKIP_TAKEN)
    EXEC_DONE = 1'b1;
    EXEC_PC_LOAD = ld;
    tick();
    EXEC_DONE = 1'b0;
    EXEC_PC_LOAD = 1'b0;
    acks = 0;
    `CHK("overflow", ovf, OVERFLOW)
  endtask
  initial
  begin
    RST_B = 1'b0; RUN = 1'b0; POWER_OK = 1'b1; HALT_ON_PARITY = 1'b1;
    INDEX_REG = 24'hFFC005; EXEC_DONE = 1'b0; EXEC_PC_LOAD = 1'b0;
    EXEC_PC_VALUE = 14'h0020; EXEC_WRITE = 1'b0; EXEC_WDATA = 24'h000123;
    {ADD_OVF, MUL_MAX_NEG, DIV_OVF, SHIFT_OVF} = 4'h0;
    lat = 4'h0; n_errors = 0; compares = 0; acks = 0;
    poke(14'h0000, mk(1'b0, 7'h35, 1'b0, 14'h0100) | 24'h800000);
    poke(14'h0001, mk(1'b1, 7'h35, 1'b0, 14'h0200));
    poke(14'h0002, mk(1'b0, 7'h35, 1'b1, 14'h0300));
    poke(14'h0300, mk(1'b1, 7'h00, 1'b1, 14'h0400));
    poke(14'h0405, mk(1'b0, 7'h00, 1'b0, 14'h0123));
    poke(14'h0003, mk(1'b0, 7'h23, 1'b0, 14'h0110));
    poke(14'h0004, mk(1'b0, 7'h20, 1'b0, 14'h0000));
    poke(14'h0005, mk(1'b0, 7'h20, 1'b0, 14'h0000));
    poke(14'h0006, mk(1'b0, 7'h29, 1'b0, 14'h0110));
    poke(14'h0007, mk(1'b0, 7'h02, 1'b0, 14'h0000));
    poke(14'h0008, mk(1'b0, 7'h35, 1'b0, 14'h0000));
    poke(14'h0020, mk(1'b0, 7'h45, 1'b0, 14'h0000));
    u_mem.mem[14'h0045] = {24'h000007, 1'b0};
    repeat (6) @(posedge CORE_CLK);
    #1 RST_B = 1'b1;
    tick();
    RUN = 1'b1;
    do_ex(14'h0000, 14'h0100, 7'h35, 1, 4'h0, 0, 0, 0, 0);
    do_ex(14'h0001, 14'h0205, 7'h35, 1, 4'h1, 0, 0, 0, 1);
    lat = 4'h3;
    do_ex(14'h0002, 14'h0123, 7'h35, 3, 4'h0, 0, 0, 0, 1);
    do_ex(14'h0003, 14'h0110, 7'h23, 1, 4'hA, 1, 0, 0, 1);
    `CHK("mark", {24'h800123, ^24'h800123}, u_mem.mem[14'h0110])
    do_ex(14'h0004, 14'h0000, 7'h20, 1, 4'h0, 0, 0, 0, 0);
    do_ex(14'h0005, 14'h0000, 7'h20, 1, 4'h0, 0, 0, 1, 0);
    do_ex(14'h0006, 14'h0110, 7'h29, 2, 4'h0, 0, 0, 0, 1);
    do_ex(14'h0007, 14'h0000, 7'h02, 1, 4'h0, 0, 0, 0, 0);
    do_ex(14'h0008, 14'h0000, 7'h35, 1, 4'h4, 0, 1, 0, 1);
    for (k = 0; k < 80 && !(MEM_REQ === 1'b1 && MEM_ADDR === 14'h0045); k++)
      tick();
    `CHK("trap save", {24'h800020, 1'b0}, u_mem.mem[14'h0000])
    `CHK("trap pc", 14'h0045, PC)
    `CHK("trap ovf", 1'b0, OVERFLOW)
    `CHK("orig", mk(1'b0, 7'h35, 1'b1, 14'h0300), u_mem.mem[2][24:1])
    for (k = 0; k < 40 && HALTED !== 1'b1; k++) tick();
    `CHK("parity", 1'b1, PARITY_ERR)
    RUN = 1'b0;
    repeat (3) tick();
    POWER_OK = 1'b0;
    RUN = 1'b1;
    repeat (8) tick();
    `CHK("power halt", 1'b1, POWER_HALT)
    `CHK("no request", 1'b0, MEM_REQ)
    summarize();
  end
  initial
  begin
    repeat (4000) @(posedge CORE_CLK);
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
